// >>> design/lhc_command_regs.sv
// Host port, command decoder, display registers and RAM write buffer of the LCD controller
`timescale 1ns/1ns
`default_nettype none

// ------------------------------------------------------------------
// Write buffer
// ------------------------------------------------------------------
module lhc_fifo #(
  parameter int WIDTH = 19,
  parameter int DEPTH = 8
) (
  input  wire logic             clk_i,
  input  wire logic             reset_i,
  input  wire logic             in_valid_i,
  input  wire logic [WIDTH-1:0] in_data_i,
  output logic                  in_ready_o,
  output logic                  out_valid_o,
  output logic      [WIDTH-1:0] out_data_o,
  input  wire logic             out_ready_i
);
  localparam int             AW   = $clog2(DEPTH);
  localparam logic [AW:0]    FULL = (AW+1)'(DEPTH);
  localparam logic [AW-1:0]  LAST = AW'(DEPTH - 1);

  typedef struct packed {
    logic [DEPTH-1:0][WIDTH-1:0] mem;
    logic [AW-1:0]               wp;
    logic [AW-1:0]               rp;
    logic [AW:0]                 cnt;
  } lhc_fifo_st_t;

  lhc_fifo_st_t q;
  lhc_fifo_st_t d;
  logic         push;
  logic         pop;

  assign in_ready_o  = (q.cnt != FULL);
  assign out_valid_o = (q.cnt != '0);
  assign out_data_o  = q.mem[q.rp];

  always_comb begin
    d    = q;
    push = in_valid_i & in_ready_o;
    pop  = out_valid_o & out_ready_i;
    if (push) begin
      d.mem[q.wp] = in_data_i;
      d.wp        = (q.wp == LAST) ? '0 : q.wp + 1'b1;
    end
    if (pop) begin
      d.rp = (q.rp == LAST) ? '0 : q.rp + 1'b1;
    end
    d.cnt = q.cnt + (AW+1)'(push) - (AW+1)'(pop);
  end

  always_ff @(posedge clk_i) begin
    if (reset_i) begin
      q <= '0;
    end else begin
      q <= d;
    end
  end
endmodule

// ------------------------------------------------------------------
// Command interpreter
// ------------------------------------------------------------------
module lhc_command_regs (
  input  wire logic       clk_i,
  input  wire logic       reset_i,
  input  wire logic       chip_sel_n_i,
  input  wire logic       reg_select_i,
  input  wire logic       read_strobe_n_i,
  input  wire logic       write_strobe_n_i,
  input  wire logic       par_mode_i,
  input  wire logic       ser_clk_i,
  input  wire logic       ser_data_i,
  input  wire logic [7:0] db_i,
  output logic      [7:0] db_o,
  output logic            db_oe_o,
  output logic            ram_wr_valid_o,
  output logic      [6:0] ram_wr_row_o,
  output logic      [3:0] ram_wr_col_o,
  output logic      [7:0] ram_wr_data_o,
  input  wire logic       ram_wr_ready_i,
  output logic            ram_rd_req_o,
  output logic      [6:0] ram_rd_row_o,
  output logic      [3:0] ram_rd_col_o,
  input  wire logic [7:0] ram_rd_data_i,
  input  wire logic       line_tick_i,
  input  wire logic       frame_tick_i,
  input  wire logic       graphic_pix_i,
  input  wire logic       icon_pix_i,
  output logic            graphic_drive_o,
  output logic            icon_drive_o,
  output logic            drive_polarity_o,
  output logic      [5:0] first_common_line_o,
  output logic      [5:0] alt_count_o,
  output logic            scan_reverse_o,
  output logic            segment_reverse_o,
  output logic            bit_swap_o,
  output logic            ext_bias_select_o,
  output logic            int_resistor_select_o,
  output logic            overrun_o
);
  typedef struct packed {
    lhc_pkg::lhc_pins_t   s1;
    lhc_pkg::lhc_pins_t   s2;
    lhc_pkg::lhc_pins_t   s3;
    lhc_pkg::lhc_phase_t  phase;
    logic [2:0]           bit_cnt;
    logic [6:0]           shift;
    logic [3:0]           col;
    logic [3:0]           row_lo;
    logic [2:0]           row_hi;
    logic [3:0]           sl_lo;
    logic [1:0]           sl_hi;
    logic [3:0]           alt_lo;
    logic [1:0]           alt_hi;
    logic [3:0]           dc1;
    logic [1:0]           ext;
    logic [3:0]           dc2;
    logic                 bank;
    logic [3:0]           rd_addr;
    logic                 pend_v;
    lhc_pkg::lhc_ram_wr_t pend;
    logic                 out_v;
    lhc_pkg::lhc_ram_wr_t out;
    logic                 rd_req;
    logic [6:0]           rd_row;
    logic [3:0]           rd_col;
    logic                 rd_flip;
    logic [7:0]           rd_buf;
    logic                 db_oe;
    logic [7:0]           db_out;
    logic                 overrun;
    logic                 polarity;
    logic [5:0]           line_cnt;
    logic                 gpix;
    logic                 ipix;
  } lhc_top_st_t;

  lhc_top_st_t          q;
  lhc_top_st_t          d;
  lhc_pkg::lhc_pins_t   pins;
  lhc_pkg::lhc_ram_wr_t fifo_out;
  logic                 fifo_in_ready;
  logic                 fifo_out_valid;
  logic                 fifo_out_ready;
  logic                 byte_v;
  logic                 byte_rs;
  logic [7:0]           byte_d;
  logic [6:0]           row;
  logic [3:0]           col_eff;
  logic                 icon_row;
  logic                 flip;
  logic                 rd_done;

  function automatic logic [7:0] mirror(input logic [7:0] b);
    logic [7:0] r;
    r = '0;
    for (int i = 0; i < 8; i++) begin
      r[i] = b[7-i];
    end
    return r;
  endfunction

  // Register readback nibble at the selected internal address
  function automatic logic [3:0] readback(input lhc_top_st_t s);
    logic [3:0] r;
    r = '0;
    case (s.rd_addr)
      lhc_pkg::CMD_COL:     r = s.col;
      lhc_pkg::CMD_ROW_LO:  r = s.row_lo;
      lhc_pkg::CMD_ROW_HI:  r = {1'b0, s.row_hi};
      lhc_pkg::CMD_SL_LO:   r = s.sl_lo;
      lhc_pkg::CMD_SL_HI:   r = {2'b00, s.sl_hi};
      lhc_pkg::CMD_ALT_LO:  r = s.alt_lo;
      lhc_pkg::CMD_ALT_HI:  r = {2'b00, s.alt_hi};
      lhc_pkg::CMD_DC1:     r = s.bank ? {2'b00, s.ext} : s.dc1;
      lhc_pkg::CMD_DC2:     r = s.dc2;
      lhc_pkg::CMD_RD_ADDR: r = s.rd_addr;
      lhc_pkg::CMD_BANK:    r = {3'b000, s.bank};
      default:              r = '0;
    endcase
    return r;
  endfunction

  // ----------------------------------------------------------------
  // Pin bundle and write buffer
  // ----------------------------------------------------------------
  always_comb begin
    pins      = '0;
    pins.cs_n = chip_sel_n_i;
    pins.rs   = reg_select_i;
    pins.rd_n = read_strobe_n_i;
    pins.wr_n = write_strobe_n_i;
    pins.par  = par_mode_i;
    pins.scl  = ser_clk_i;
    pins.sda  = ser_data_i;
    pins.db   = db_i;
  end

  assign fifo_out_ready = ~q.out_v | ram_wr_ready_i;

  lhc_fifo #(
    .WIDTH ($bits(lhc_pkg::lhc_ram_wr_t)),
    .DEPTH (lhc_pkg::FIFO_DEPTH)
  ) u_fifo (
    .clk_i       (clk_i),
    .reset_i     (reset_i),
    .in_valid_i  (q.pend_v),
    .in_data_i   (q.pend),
    .in_ready_o  (fifo_in_ready),
    .out_valid_o (fifo_out_valid),
    .out_data_o  (fifo_out),
    .out_ready_i (fifo_out_ready)
  );

  // ----------------------------------------------------------------
  // Next state
  // ----------------------------------------------------------------
  always_comb begin
    d       = q;
    d.s1    = pins;
    d.s2    = q.s1;
    d.s3    = q.s2;
    d.rd_req = 1'b0;
    byte_v  = 1'b0;
    byte_rs = q.s2.rs;
    byte_d  = q.s2.db;
    rd_done = 1'b0;
    row      = {q.row_hi, q.row_lo};
    icon_row = (row >= lhc_pkg::ICON_ROW_LO);
    col_eff  = q.dc2[lhc_pkg::DC2_REF] ? lhc_pkg::COL_MAX - q.col : q.col;
    flip     = ~icon_row & (q.dc2[lhc_pkg::DC2_REF] ^ q.dc2[lhc_pkg::DC2_SWAP]);

    // Parallel port: a strobe counts only inside chip select
    unique case (q.phase)
      lhc_pkg::ST_IDLE: begin
        if (q.s2.par && !q.s2.cs_n && !q.s2.wr_n) begin
          d.phase = lhc_pkg::ST_WRITE;
        end else if (q.s2.par && !q.s2.cs_n && !q.s2.rd_n) begin
          d.phase  = lhc_pkg::ST_READ;
          d.db_oe  = 1'b1;
          d.db_out = q.s2.rs ? {4'h0, readback(q)} : q.rd_buf;
        end
      end
      lhc_pkg::ST_WRITE: begin
        if (q.s2.cs_n) begin
          d.phase = lhc_pkg::ST_IDLE;
        end else if (q.s2.wr_n) begin
          byte_v  = 1'b1;
          d.phase = lhc_pkg::ST_IDLE;
        end
      end
      lhc_pkg::ST_READ: begin
        if (q.s2.cs_n || q.s2.rd_n) begin
          d.db_oe = 1'b0;
          d.phase = lhc_pkg::ST_IDLE;
          rd_done = ~q.s2.cs_n & ~q.s2.rs & ~q.bank;
        end
      end
    endcase

    // Serial port: write only, shifted on serial clock rise
    if (q.s2.par || q.s2.cs_n) begin
      d.bit_cnt = '0;
    end else if (q.s2.scl && !q.s3.scl) begin
      d.shift   = {q.shift[5:0], q.s2.sda};
      d.bit_cnt = q.bit_cnt + 3'h1;
      if (q.bit_cnt == lhc_pkg::SER_LAST_BIT) begin
        byte_v = 1'b1;
        byte_d = {q.shift, q.s2.sda};
      end
    end

    // RAM read: fetch after strobe ends, so the next read returns it
    if (rd_done) begin
      d.rd_req  = 1'b1;
      d.rd_row  = row;
      d.rd_col  = col_eff;
      d.rd_flip = flip;
    end
    if (q.rd_req) begin
      d.rd_buf = q.rd_flip ? mirror(ram_rd_data_i) : ram_rd_data_i;
    end

    // Write buffer hand-off
    if (q.pend_v && fifo_in_ready) begin
      d.pend_v = 1'b0;
    end
    if (fifo_out_ready) begin
      d.out_v = fifo_out_valid;
      d.out   = fifo_out;
    end

    // Byte decode
    if (byte_v && !byte_rs) begin
      if (!q.bank) begin
        if (d.pend_v) begin
          d.overrun = 1'b1;
        end else begin
          d.pend_v    = 1'b1;
          d.pend.row  = row;
          d.pend.col  = col_eff;
          d.pend.data = flip ? mirror(byte_d) : byte_d;
        end
      end
    end else if (byte_v) begin
      unique case (byte_d[7:4])
        lhc_pkg::CMD_COL:     d.col    = q.bank ? q.col : byte_d[3:0];
        lhc_pkg::CMD_ROW_LO:  d.row_lo = q.bank ? q.row_lo : byte_d[3:0];
        lhc_pkg::CMD_ROW_HI:  d.row_hi = q.bank ? q.row_hi : byte_d[2:0];
        lhc_pkg::CMD_SL_LO:   d.sl_lo  = q.bank ? q.sl_lo : byte_d[3:0];
        lhc_pkg::CMD_SL_HI:   d.sl_hi  = q.bank ? q.sl_hi : byte_d[1:0];
        lhc_pkg::CMD_ALT_LO:  d.alt_lo = q.bank ? q.alt_lo : byte_d[3:0];
        lhc_pkg::CMD_ALT_HI:  d.alt_hi = q.bank ? q.alt_hi : byte_d[1:0];
        lhc_pkg::CMD_DC1: begin
          if (q.bank) begin
            d.ext = byte_d[1:0];
          end else begin
            d.dc1 = byte_d[3:0];
          end
        end
        lhc_pkg::CMD_DC2:     d.dc2     = q.bank ? q.dc2 : byte_d[3:0];
        lhc_pkg::CMD_RD_ADDR: d.rd_addr = q.bank ? q.rd_addr : byte_d[3:0];
        lhc_pkg::CMD_BANK:    d.bank    = byte_d[0];
        default:              d.bank    = q.bank;
      endcase
    end

    // Drive polarity: per frame, or every k+1 lines
    if (frame_tick_i) begin
      d.line_cnt = '0;
      if (!q.dc2[lhc_pkg::DC2_LINE_ALT_ENABLE]) begin
        d.polarity = ~q.polarity;
      end
    end else if (line_tick_i && q.dc2[lhc_pkg::DC2_LINE_ALT_ENABLE]) begin
      if (q.line_cnt == {q.alt_hi, q.alt_lo}) begin
        d.line_cnt = '0;
        d.polarity = ~q.polarity;
      end else begin
        d.line_cnt = q.line_cnt + 6'h01;
      end
    end

    // Pixel drive
    d.gpix = q.dc1[lhc_pkg::DC1_ON]
           & (q.dc1[lhc_pkg::DC1_ALL_PIXELS_LIT]
           | (graphic_pix_i ^ q.dc2[lhc_pkg::DC2_INV]));
    d.ipix = q.dc1[lhc_pkg::DC1_ICON] & icon_pix_i;
  end

  always_ff @(posedge clk_i) begin
    if (reset_i) begin
      q         <= '0;
      q.s1      <= '1;
      q.s2      <= '1;
      q.s3      <= '1;
      q.phase   <= lhc_pkg::ST_IDLE;
      q.col     <= lhc_pkg::RST_NIBBLE;
      q.dc1     <= lhc_pkg::RST_NIBBLE;
      q.dc2     <= lhc_pkg::RST_NIBBLE;
      q.rd_addr <= lhc_pkg::RST_RD_ADDR;
    end else begin
      q <= d;
    end
  end

  // ----------------------------------------------------------------
  // Outputs
  // ----------------------------------------------------------------
  assign db_o                  = q.db_out;
  assign db_oe_o               = q.db_oe;
  assign ram_wr_valid_o        = q.out_v;
  assign ram_wr_row_o          = q.out.row;
  assign ram_wr_col_o          = q.out.col;
  assign ram_wr_data_o         = q.out.data;
  assign ram_rd_req_o          = q.rd_req;
  assign ram_rd_row_o          = q.rd_row;
  assign ram_rd_col_o          = q.rd_col;
  assign graphic_drive_o       = q.gpix;
  assign icon_drive_o          = q.ipix;
  assign drive_polarity_o      = q.polarity;
  assign first_common_line_o   = {q.sl_hi, q.sl_lo};
  assign alt_count_o           = {q.alt_hi, q.alt_lo};
  assign scan_reverse_o        = q.dc1[lhc_pkg::DC1_SCAN];
  assign segment_reverse_o     = q.dc2[lhc_pkg::DC2_REF];
  assign bit_swap_o            = q.dc2[lhc_pkg::DC2_SWAP];
  assign ext_bias_select_o     = q.ext[lhc_pkg::EXT_BIAS];
  assign int_resistor_select_o = q.ext[lhc_pkg::EXT_INT_R];
  assign overrun_o             = q.overrun;
endmodule

`default_nettype wire

// >>> design/lhc_pkg.sv
// Package: command codes, field positions, reset values and carrier types of the LCD host port
// What this block does
// - Register select low means RAM data; high means register command byte.
// - RAM data write with extended bank off stores byte at current column and row.
// - First RAM read after address load is a dummy; host discards it.
// - Upper nibble 0 loads 4-bit column; reset zero; reads back at 0.
// - Segment reverse set addresses RAM at 15 minus the column value.
// - Row loads as low nibble (code 2) then high 3 bits (code 3); reset zero.
// - Rows 0 to 0x42 valid; rows 0x40 to 0x42 select icon RAM.
// - Six-bit start line from codes 4 and 5 drives the first common line.
// - Alternation count from codes 6 and 7; value k selects k+1 lines.
// - Count used only with line alternation on; otherwise polarity flips per frame.
// - With display on, all pixels lit forces graphic pixels on and overrides inversion.
// - Icon segments off holds icon outputs at ground.
// - Code 9 holds invert, line alternation, bit swap, segment reverse; reset zero.
// - Segment reverse mirrors column and flips graphic bit order; bit swap set as well cancels the flip.
// - For icon RAM segment reverse remaps column but keeps bit order.
// - Serial data sampled on serial clock rise; eighth rise ends a byte; writes only.
// - With line alternation on, polarity flips every k+1 lines.
package lhc_pkg;
  // ----------------------------------------------------------------
  // Command codes (upper nibble of a register byte)
  // ----------------------------------------------------------------
  localparam logic [3:0] CMD_COL      = 4'h0;
  localparam logic [3:0] CMD_ROW_LO   = 4'h2;
  localparam logic [3:0] CMD_ROW_HI   = 4'h3;
  localparam logic [3:0] CMD_SL_LO    = 4'h4;
  localparam logic [3:0] CMD_SL_HI    = 4'h5;
  localparam logic [3:0] CMD_ALT_LO   = 4'h6;
  localparam logic [3:0] CMD_ALT_HI   = 4'h7;
  localparam logic [3:0] CMD_DC1      = 4'h8;
  localparam logic [3:0] CMD_DC2      = 4'h9;
  localparam logic [3:0] CMD_RD_ADDR  = 4'hc;
  localparam logic [3:0] CMD_BANK     = 4'hf;
  // ----------------------------------------------------------------
  // Reset values and limits
  // ----------------------------------------------------------------
  localparam logic [3:0] RST_NIBBLE   = 4'h0;
  localparam logic [3:0] RST_RD_ADDR  = 4'hc;
  localparam logic [3:0] COL_MAX      = 4'hf;
  localparam logic [6:0] ICON_ROW_LO  = 7'h40;
  localparam logic [2:0] SER_LAST_BIT = 3'h7;
  localparam int         FIFO_DEPTH   = 8;
  // ----------------------------------------------------------------
  // Field positions
  // ----------------------------------------------------------------
  localparam int DC1_ON    = 0;
  localparam int DC1_ALL_PIXELS_LIT = 1;
  localparam int DC1_ICON  = 2;
  localparam int DC1_SCAN  = 3;
  localparam int DC2_REF   = 0;
  localparam int DC2_SWAP  = 1;
  localparam int DC2_LINE_ALT_ENABLE  = 2;
  localparam int DC2_INV   = 3;
  localparam int EXT_INT_R = 0;
  localparam int EXT_BIAS  = 1;
  // ----------------------------------------------------------------
  // Carrier types
  // ----------------------------------------------------------------
  typedef struct packed {
    logic       cs_n;
    logic       rs;
    logic       rd_n;
    logic       wr_n;
    logic       par;
    logic       scl;
    logic       sda;
    logic [7:0] db;
  } lhc_pins_t;

  typedef struct packed {
    logic [6:0] row;
    logic [3:0] col;
    logic [7:0] data;
  } lhc_ram_wr_t;

  typedef enum logic [1:0] {
    ST_IDLE  = 2'b00,
    ST_WRITE = 2'b01,
    ST_READ  = 2'b10
  } lhc_phase_t;
endpackage

// >>> testbench/lhc_command_regs_bench.sv
// Self-checking bench of the LCD host command registers
`timescale 1ns/1ns
`default_nettype none
module lhc_command_regs_bench;
  logic               clk_i = 1'b0;
  logic               reset_i = 1'b1;
  lhc_pkg::lhc_pins_t pins;
  logic [7:0]         db_o, db_bus, ram_wr_data_o, ram_rd_data_i, rd_val;
  logic               db_oe_o, ram_wr_valid_o, ram_rd_req_o, overrun_o;
  logic               ram_wr_ready_i = 1'b1;
  logic [6:0]         ram_wr_row_o, ram_rd_row_o;
  logic [3:0]         ram_wr_col_o, ram_rd_col_o;
  logic               line_tick_i = 1'b0, frame_tick_i = 1'b0;
  logic               graphic_pix_i = 1'b0, icon_pix_i = 1'b0;
  logic               graphic_drive_o, icon_drive_o, drive_polarity_o, scan_reverse_o;
  logic               segment_reverse_o, bit_swap_o, ext_bias_select_o, int_resistor_select_o;
  logic [5:0]         first_common_line_o, alt_count_o;
  logic [18:0]        last_wr = 19'h0;
  int                 wr_seen = 0;
  int                 error_cnt = 0;
  int                 n_checks = 0;

  always #5 clk_i = ~clk_i;
  assign db_bus = db_oe_o ? db_o : pins.db;
  assign ram_rd_data_i = {ram_rd_col_o, ram_rd_row_o[3:0]};

  lhc_host u_lhc_host (.clk_i(clk_i), .db_i(db_bus), .pins_o(pins));
  lhc_command_regs u_lhc_command_regs (
    .clk_i, .reset_i, .chip_sel_n_i(pins.cs_n), .reg_select_i(pins.rs),
    .read_strobe_n_i(pins.rd_n), .write_strobe_n_i(pins.wr_n), .par_mode_i(pins.par),
    .ser_clk_i(pins.scl), .ser_data_i(pins.sda), .db_i(db_bus), .db_o, .db_oe_o,
    .ram_wr_valid_o, .ram_wr_row_o, .ram_wr_col_o, .ram_wr_data_o, .ram_wr_ready_i,
    .ram_rd_req_o, .ram_rd_row_o, .ram_rd_col_o, .ram_rd_data_i, .line_tick_i, .frame_tick_i,
    .graphic_pix_i, .icon_pix_i, .graphic_drive_o, .icon_drive_o, .drive_polarity_o,
    .first_common_line_o, .alt_count_o, .scan_reverse_o, .segment_reverse_o, .bit_swap_o,
    .ext_bias_select_o, .int_resistor_select_o, .overrun_o);

  // ----------------------------------------------------------------
  // RAM side: records every accepted display write
  // ----------------------------------------------------------------
  always @(posedge clk_i) begin
    if (ram_wr_valid_o === 1'b1 && ram_wr_ready_i === 1'b1) begin
      last_wr <= {ram_wr_row_o, ram_wr_col_o, ram_wr_data_o};
      wr_seen <= wr_seen + 1;
    end
  end

  // ----------------------------------------------------------------
  // Helpers
  // ----------------------------------------------------------------
  task automatic check(input string what, input logic [19:0] seen, input logic [19:0] exp);
    n_checks++;
    if (seen !== exp) begin
      error_cnt++;
      $display("CHECK FAILED %s expected %h seen %h", what, exp, seen);
    end
  endtask

  task automatic tally_and_finish();
    $display("mismatches %0d, comparisons %0d", error_cnt, n_checks);
    if (error_cnt == 0 && n_checks > 0)
      $display("Run complete: PASS");
    else
      $display("Run complete: FAIL");
    $finish;
  endtask

  task automatic cmd(input logic [7:0] b);
    u_lhc_host.par_wr(1'b1, b);
  endtask

  task automatic ram_wr(input logic [7:0] d, input logic [18:0] exp, input string what);
    u_lhc_host.par_wr(1'b0, d);
    check(what, last_wr, exp);
  endtask

  task automatic pulse(input logic frame);
    @(negedge clk_i);
    frame_tick_i = frame;
    line_tick_i = ~frame;
    @(negedge clk_i);
    frame_tick_i = 1'b0;
    line_tick_i = 1'b0;
    repeat (3) @(negedge clk_i);
  endtask

  task automatic pix(input logic g, input logic i, input logic [1:0] exp, input string what);
    @(negedge clk_i);
    graphic_pix_i = g;
    icon_pix_i = i;
    repeat (2) @(negedge clk_i);
    check(what, {graphic_drive_o, icon_drive_o}, exp);
  endtask

  // ----------------------------------------------------------------
  // Scenarios
  // ----------------------------------------------------------------
  task automatic t_regs();
    check("reset outputs", {segment_reverse_o, bit_swap_o, scan_reverse_o, ext_bias_select_o,
      int_resistor_select_o, db_oe_o, ram_wr_valid_o, drive_polarity_o, first_common_line_o,
      alt_count_o}, 20'h0);
    cmd(8'h53);
    cmd(8'h45);
    check("start line", first_common_line_o, 6'h35);
    u_lhc_host.ser_wr(1'b1, 8'h4a);
    check("serial start line", first_common_line_o, 6'h3a);
    cmd(8'h61);
    cmd(8'h73);
    check("alt count", alt_count_o, 6'h31);
    cmd(8'h9b);
    cmd(8'hc9);
    u_lhc_host.par_rd(1'b1, rd_val);
    check("control two", {bit_swap_o, segment_reverse_o, rd_val}, {2'b11, 8'h0b});
    cmd(8'h88);
    check("scan reverse", scan_reverse_o, 1'b1);
    cmd(8'h80);
    cmd(8'hf1);
    cmd(8'h82);
    cmd(8'hf0);
    check("ext control", {ext_bias_select_o, int_resistor_select_o, scan_reverse_o}, 3'b100);
  endtask

  task automatic t_ram();
    int n0;
    cmd(8'h90);
    cmd(8'h03);
    cmd(8'h25);
    cmd(8'h31);
    ram_wr(8'h0d, {7'h15, 4'h3, 8'h0d}, "plain write");
    cmd(8'h91);
    ram_wr(8'h0d, {7'h15, 4'hc, 8'hb0}, "mirrored write");
    cmd(8'h93);
    ram_wr(8'h0d, {7'h15, 4'hc, 8'h0d}, "swapped mirror");
    cmd(8'h20);
    cmd(8'h34);
    cmd(8'h91);
    ram_wr(8'h0d, {7'h40, 4'hc, 8'h0d}, "icon write");
    n0 = wr_seen;
    cmd(8'hf1);
    u_lhc_host.par_wr(1'b0, 8'h77);
    cmd(8'hf0);
    check("ext bank write", 20'(wr_seen - n0), 20'h0);
  endtask

  task automatic t_read();
    cmd(8'h90);
    cmd(8'h05);
    cmd(8'h22);
    cmd(8'h30);
    u_lhc_host.par_rd(1'b0, rd_val);
    check("dummy read", rd_val == 8'h52, 1'b0);
    u_lhc_host.par_rd(1'b0, rd_val);
    check("ram read", {ram_rd_row_o, ram_rd_col_o, rd_val}, {7'h02, 4'h5, 8'h52});
  endtask

  task automatic t_polarity();
    pulse(1'b0);
    check("line ignored", drive_polarity_o, 1'b0);
    pulse(1'b1);
    check("frame flip", drive_polarity_o, 1'b1);
    cmd(8'h61);
    cmd(8'h70);
    cmd(8'h94);
    pulse(1'b0);
    check("first line", drive_polarity_o, 1'b1);
    pulse(1'b0);
    check("second line", drive_polarity_o, 1'b0);
  endtask

  task automatic t_pixels();
    cmd(8'h90);
    cmd(8'h85);
    pix(1'b1, 1'b1, 2'b11, "on follows");
    pix(1'b0, 1'b1, 2'b01, "pixel off");
    cmd(8'h98);
    pix(1'b0, 1'b1, 2'b11, "inverted");
    cmd(8'h83);
    pix(1'b1, 1'b1, 2'b10, "all lit");
    cmd(8'h82);
    pix(1'b1, 1'b1, 2'b00, "blanked");
  endtask

  task automatic t_fifo();
    int n0;
    int sent;
    n0 = wr_seen;
    sent = 0;
    ram_wr_ready_i = 1'b0;
    while (overrun_o !== 1'b1 && sent < 12) begin
      u_lhc_host.par_wr(1'b0, 8'(sent));
      sent++;
    end
    check("stalled", 20'(wr_seen - n0), 20'h0);
    check("fill depth", sent > lhc_pkg::FIFO_DEPTH, 1'b1);
    ram_wr_ready_i = 1'b1;
    repeat (30) @(negedge clk_i);
    check("drained", 20'(wr_seen - n0), 20'(sent - 1));
    reset_i = 1'b1;
    repeat (5) @(negedge clk_i);
    reset_i = 1'b0;
    repeat (2) @(negedge clk_i);
    check("overrun cleared", overrun_o, 1'b0);
  endtask

  // ----------------------------------------------------------------
  // Sequence and watchdog
  // ----------------------------------------------------------------
  initial begin
    repeat (5) @(negedge clk_i);
    reset_i = 1'b0;
    repeat (2) @(negedge clk_i);
    t_regs();
    t_ram();
    t_read();
    t_polarity();
    t_pixels();
    t_fifo();
    tally_and_finish();
  end

  initial begin
    repeat (20000) @(posedge clk_i);
    error_cnt++;
    tally_and_finish();
  end
endmodule
`default_nettype wire

// >>> testbench/lhc_command_regs_chk.sv
// Port-level assertions of the LCD host command registers
`timescale 1ns/1ns
`default_nettype none
module lhc_command_regs_chk (
  input wire logic       clk_i,
  input wire logic       reset_i,
  input wire logic       chip_sel_n_i,
  input wire logic       par_mode_i,
  input wire logic       ram_wr_ready_i,
  input wire logic       icon_pix_i,
  input wire logic       line_tick_i,
  input wire logic       frame_tick_i,
  input wire logic       db_oe_o,
  input wire logic       ram_wr_valid_o,
  input wire logic [6:0] ram_wr_row_o,
  input wire logic [3:0] ram_wr_col_o,
  input wire logic [7:0] ram_wr_data_o,
  input wire logic       ram_rd_req_o,
  input wire logic       icon_drive_o,
  input wire logic       drive_polarity_o,
  input wire logic [5:0] first_common_line_o,
  input wire logic [5:0] alt_count_o,
  input wire logic       segment_reverse_o,
  input wire logic       overrun_o
);
  default clocking cb @(posedge clk_i); endclocking
  default disable iff (reset_i);
  // ----------------------------------------------------------------
  // Sequences
  // ----------------------------------------------------------------
  sequence s_cs_idle;
    chip_sel_n_i [*6];
  endsequence
  sequence s_serial_run;
    !par_mode_i [*4];
  endsequence
  sequence s_stalled;
    ram_wr_valid_o && !ram_wr_ready_i;
  endsequence
  // ----------------------------------------------------------------
  // Assertions
  // ----------------------------------------------------------------
  chk_cs_ignored: assert property (s_cs_idle |-> !db_oe_o && $stable(first_common_line_o)
    && $stable(alt_count_o) && $stable(segment_reverse_o)) else $error("deselected port acted");
  chk_serial_no_read: assert property (s_serial_run |-> !db_oe_o)
    else $error("bus driven in serial mode");
  chk_wr_hold: assert property (s_stalled |=> ram_wr_valid_o
    && $stable({ram_wr_row_o, ram_wr_col_o, ram_wr_data_o})) else $error("stalled write moved");
  chk_rd_pulse: assert property (ram_rd_req_o |=> !ram_rd_req_o)
    else $error("read request longer than one cycle");
  chk_pol_cause: assert property ($changed(drive_polarity_o) |-> $past(frame_tick_i)
    || $past(line_tick_i) || $past(frame_tick_i, 2) || $past(line_tick_i, 2))
    else $error("polarity changed without a tick");
  chk_icon_gate: assert property (icon_drive_o |-> $past(icon_pix_i))
    else $error("icon driven without icon pixel");
  chk_overrun_sticky: assert property (overrun_o |=> overrun_o)
    else $error("overrun flag dropped");
  chk_reset_clear: assert property ($fell(reset_i) |-> !db_oe_o && !ram_wr_valid_o
    && !drive_polarity_o && !segment_reverse_o && first_common_line_o == 6'h00
    && alt_count_o == 6'h00) else $error("outputs not cleared by reset");
endmodule

bind lhc_command_regs lhc_command_regs_chk u_chk (
  .clk_i, .reset_i, .chip_sel_n_i, .par_mode_i, .ram_wr_ready_i, .icon_pix_i, .line_tick_i,
  .frame_tick_i, .db_oe_o, .ram_wr_valid_o, .ram_wr_row_o, .ram_wr_col_o, .ram_wr_data_o,
  .ram_rd_req_o, .icon_drive_o, .drive_polarity_o, .first_common_line_o, .alt_count_o,
  .segment_reverse_o, .overrun_o
);
`default_nettype wire

// >>> testbench/lhc_host.sv
// Host processor model driving the parallel and serial pins
`timescale 1ns/1ns
`default_nettype none
module lhc_host (
  input  wire logic         clk_i,
  input  wire logic [7:0]   db_i,
  output var lhc_pkg::lhc_pins_t pins_o
);
  // Idle: deselected, parallel mode, strobes high, serial clock low
  initial pins_o = '{1'b1, 1'b0, 1'b1, 1'b1, 1'b1, 1'b0, 1'b0, 8'h00};

  task automatic wait_n(input int n);
    repeat (n) @(negedge clk_i);
  endtask

  task automatic par_wr(input logic rs, input logic [7:0] d);
    wait_n(1);
    pins_o.par = 1'b1;
    pins_o.cs_n = 1'b0;
    pins_o.rs = rs;
    pins_o.db = d;
    wait_n(6);
    pins_o.wr_n = 1'b0;
    wait_n(6);
    pins_o.wr_n = 1'b1;
    wait_n(6);
    pins_o.cs_n = 1'b1;
    pins_o.db = ~d;
    wait_n(2);
  endtask

  task automatic par_rd(input logic rs, output logic [7:0] d);
    wait_n(1);
    pins_o.cs_n = 1'b0;
    pins_o.rs = rs;
    wait_n(6);
    pins_o.rd_n = 1'b0;
    wait_n(8);
    d = db_i;
    pins_o.rd_n = 1'b1;
    wait_n(6);
    pins_o.cs_n = 1'b1;
    wait_n(2);
  endtask

  task automatic ser_wr(input logic rs, input logic [7:0] d);
    wait_n(1);
    pins_o.par = 1'b0;
    pins_o.cs_n = 1'b0;
    pins_o.rs = rs;
    for (int i = 7; i >= 0; i--) begin
      pins_o.sda = d[i];
      wait_n(4);
      pins_o.scl = 1'b1;
      wait_n(4);
      pins_o.scl = 1'b0;
    end
    pins_o.sda = ~d[0];
    wait_n(6);
    pins_o.cs_n = 1'b1;
    pins_o.par = 1'b1;
    wait_n(2);
  endtask
endmodule
`default_nettype wire
